// *** mem_bank_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module mem_bank_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic acc_req,
	input wire logic acc_write,
	input wire logic [7:0] cs,
	input wire logic [7:0] bad_parity,
	output logic par_error
);
	logic last_write;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			last_write <= 1'b0;
		else if (acc_req)
			last_write <= acc_write;
	end
	// Bad parity is seen only when a faulty bank returns read data
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			par_error <= 1'b0;
		else
			par_error <= !last_write && (|(cs & bad_parity));
	end
endmodule : mem_bank_model
`default_nettype wire

// *** memctl_pkg.sv ***
package memctl_pkg;
	localparam int NUM_BANKS = 8;
	localparam int RADDR_W = 8;
	// Register offsets
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_PRESCALE = 8'h04;
	localparam logic [7:0] OFS_CONTROL = 8'h08;
	localparam logic [1:0] BANK_REGION = 2'h1;
	localparam logic [1:0] WORD_ALIGN = 2'h0;
	localparam int BANK_IDX_LSB = 3;
	localparam int BANK_SEL_BIT = 2;
	// Status register: bit n of the big-endian numbering sits at data bit STAT_MSB - n
	localparam int STAT_MSB = 15;
	localparam int NUM_FLAGS = 9;
	localparam int WP_FLAG = 8;
	// Prescaler select field
	localparam int PSEL_LSB = 8;
	localparam int PSEL_W = 8;
	// Control register
	localparam int CTRL_BUSMON = 0;
	localparam logic CTRL_BUSMON_RST = 1'b0;
	// Base register fields
	localparam int BA_LSB = 15;
	localparam int BA_W = 17;
	localparam int ATYPE_LSB = 12;
	localparam int ATYPE_W = 3;
	localparam int PORTW_LSB = 10;
	localparam int PAR_EN_BIT = 9;
	localparam int WP_BIT = 8;
	localparam int MSEL_LSB = 6;
	localparam int V_BIT = 0;
	localparam logic [31:0] BASE_WMASK = 32'hFFFF_FFC1;
	// Option register: mask fields share the base field positions
	localparam logic [31:0] BASE0_RST = 32'h0000_0001;
	localparam logic [31:0] OPT0_RST = 32'h0000_0FF4;
	localparam logic [31:0] REG_RST = 32'h0000_0000;
	// Port size codes and widths in bits
	localparam logic [1:0] PORTW_32 = 2'h0;
	localparam logic [1:0] PORTW_8 = 2'h1;
	localparam logic [1:0] PORTW_16 = 2'h2;
	localparam logic [5:0] WIDTH_32 = 6'h20;
	localparam logic [5:0] WIDTH_16 = 6'h10;
	localparam logic [5:0] WIDTH_8 = 6'h08;
	localparam logic [5:0] WIDTH_NONE = 6'h00;
	// Machine select codes and one-hot outputs
	localparam logic [1:0] MSEL_GEN = 2'h0;
	localparam logic [1:0] MSEL_A = 2'h2;
	localparam logic [1:0] MSEL_B = 2'h3;
	localparam logic [2:0] MACH_GEN = 3'h1;
	localparam logic [2:0] MACH_A = 3'h2;
	localparam logic [2:0] MACH_B = 3'h4;
	localparam logic [2:0] MACH_NONE = 3'h0;
	localparam int DIV_W = 7;
	localparam logic [6:0] DIV_NONE = 7'h00;
endpackage : memctl_pkg

// *** memctl_regs.sv ***
`timescale 1ns/10ps
`default_nettype none
module memctl_regs
	import memctl_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [RADDR_W-1:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA,
	input wire logic ACC_REQ,
	input wire logic [31:0] ACC_ADDR,
	input wire logic [ATYPE_W-1:0] ACC_TYPE,
	input wire logic ACC_WRITE,
	input wire logic PAR_ERROR,
	input wire logic BAUD_GEN_CLOCK,
	output logic [NUM_BANKS-1:0] BANK_CHIP_SELECT,
	output logic TRANSFER_ACKNOWLEDGE,
	output logic TRANSFER_ERROR,
	output logic [5:0] ACC_PORT_WIDTH,
	output logic [2:0] ACC_MACHINE,
	output logic ACC_PARITY_ENABLE,
	output logic PTIMER_TICK
);
	logic [31:0] bank_base [NUM_BANKS];
	logic [31:0] bank_option [NUM_BANKS];
	logic [NUM_FLAGS-1:0] err_flags;
	logic [PSEL_W-1:0] prescale_select;
	logic bus_mon_en;
	logic [NUM_BANKS-1:0] hit_vec;
	logic [NUM_BANKS-1:0] valid_vec;
	logic [NUM_BANKS-1:0] sel_onehot;
	logic [2:0] sel_idx;
	logic any_hit;
	logic blocked;
	logic grant;
	logic [2:0] par_bank;
	logic par_armed;
	logic [NUM_FLAGS-1:0] set_mask;
	logic [NUM_FLAGS-1:0] clr_mask;
	logic status_wr;
	logic [31:0] next_rdata;
	logic [31:0] sel_base;
	logic ptimer_tick;

	prescale_if pif();

	// Bank register decode, shared by read and write paths
	function automatic logic is_bank_addr(input logic [RADDR_W-1:0] a);
		return a[7:6] == BANK_REGION && a[1:0] == WORD_ALIGN;
	endfunction : is_bank_addr

	// Address and type compare under masks
	function automatic logic bank_hit(input logic [31:0] br, input logic [31:0] om,
		input logic [31:0] addr, input logic [ATYPE_W-1:0] atype);
		logic [BA_W-1:0] adiff;
		logic [ATYPE_W-1:0] tdiff;
		adiff = (addr[BA_LSB +: BA_W] ^ br[BA_LSB +: BA_W]) & om[BA_LSB +: BA_W];
		tdiff = (atype ^ br[ATYPE_LSB +: ATYPE_W]) & om[ATYPE_LSB +: ATYPE_W];
		return br[V_BIT] && adiff == '0 && tdiff == '0;
	endfunction : bank_hit

	function automatic logic [5:0] width_of(input logic [1:0] ps);
		logic [5:0] w;
		w = WIDTH_NONE;
		case (ps)
			PORTW_32: w = WIDTH_32;
			PORTW_8: w = WIDTH_8;
			PORTW_16: w = WIDTH_16;
			default: w = WIDTH_NONE;
		endcase
		return w;
	endfunction : width_of

	function automatic logic [2:0] machine_of(input logic [1:0] ms);
		logic [2:0] m;
		m = MACH_NONE;
		case (ms)
			MSEL_GEN: m = MACH_GEN;
			MSEL_A: m = MACH_A;
			MSEL_B: m = MACH_B;
			default: m = MACH_NONE;
		endcase
		return m;
	endfunction : machine_of

	always_comb begin
		for (int i = 0; i < NUM_BANKS; i++) begin
			hit_vec[i] = bank_hit(bank_base[i], bank_option[i], ACC_ADDR, ACC_TYPE);
			valid_vec[i] = bank_base[i][V_BIT];
		end
	end

	// Lowest numbered hitting bank wins
	always_comb begin
		sel_idx = 3'h0;
		sel_onehot = '0;
		for (int i = NUM_BANKS - 1; i >= 0; i--) begin
			if (hit_vec[i]) begin
				sel_idx = 3'(i);
				sel_onehot = NUM_BANKS'(1) << i;
			end
		end
	end

	assign any_hit = |hit_vec;
	assign sel_base = bank_base[sel_idx];
	// Writes into protected bank are blocked
	assign blocked = ACC_REQ && any_hit && ACC_WRITE && sel_base[WP_BIT];
	assign grant = ACC_REQ && any_hit && !blocked;
	assign status_wr = REG_WR && REG_ADDR == OFS_STATUS;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			for (int i = 0; i < NUM_BANKS; i++) begin
				bank_base[i] <= (i == 0) ? BASE0_RST : REG_RST;
				bank_option[i] <= (i == 0) ? OPT0_RST : REG_RST;
			end
		end else if (REG_WR && is_bank_addr(REG_ADDR)) begin
			if (REG_ADDR[BANK_SEL_BIT]) begin
				bank_option[REG_ADDR[BANK_IDX_LSB +: 3]] <= REG_WDATA;
			end else begin
				bank_base[REG_ADDR[BANK_IDX_LSB +: 3]] <= REG_WDATA & BASE_WMASK;
			end
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			prescale_select <= '0;
			bus_mon_en <= CTRL_BUSMON_RST;
		end else if (REG_WR && REG_ADDR == OFS_PRESCALE) begin
			prescale_select <= REG_WDATA[PSEL_LSB +: PSEL_W];
		end else if (REG_WR && REG_ADDR == OFS_CONTROL) begin
			bus_mon_en <= REG_WDATA[CTRL_BUSMON];
		end
	end

	// Remember bank of last read and whether it is checked
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			par_bank <= 3'h0;
			par_armed <= 1'b0;
		end else if (grant && !ACC_WRITE) begin
			par_bank <= sel_idx;
			par_armed <= sel_base[PAR_EN_BIT];
		end
	end

	// Event and clear masks, flag index n is status bit n
	always_comb begin
		set_mask = '0;
		clr_mask = '0;
		if (PAR_ERROR && par_armed) begin
			set_mask[par_bank] = 1'b1;
		end
		if (blocked) begin
			set_mask[WP_FLAG] = 1'b1;
		end
		for (int i = 0; i < NUM_FLAGS; i++) begin
			clr_mask[i] = status_wr && REG_WDATA[STAT_MSB - i];
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			err_flags <= '0;
		end else begin
			err_flags <= (err_flags & ~clr_mask) | set_mask;
		end
	end

	// Read mux
	always_comb begin
		next_rdata = '0;
		if (REG_ADDR == OFS_STATUS) begin
			for (int i = 0; i < NUM_FLAGS; i++) begin
				next_rdata[STAT_MSB - i] = err_flags[i];
			end
		end else if (REG_ADDR == OFS_PRESCALE) begin
			next_rdata[PSEL_LSB +: PSEL_W] = prescale_select;
		end else if (REG_ADDR == OFS_CONTROL) begin
			next_rdata[CTRL_BUSMON] = bus_mon_en;
		end else if (is_bank_addr(REG_ADDR)) begin
			if (REG_ADDR[BANK_SEL_BIT]) begin
				next_rdata = bank_option[REG_ADDR[BANK_IDX_LSB +: 3]];
			end else begin
				next_rdata = bank_base[REG_ADDR[BANK_IDX_LSB +: 3]];
			end
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			REG_RDATA <= '0;
		end else if (REG_RD) begin
			REG_RDATA <= next_rdata;
		end else begin
			REG_RDATA <= '0;
		end
	end

	// Chip select and acknowledge only on valid unblocked hit
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			BANK_CHIP_SELECT <= '0;
			TRANSFER_ACKNOWLEDGE <= 1'b0;
		end else begin
			BANK_CHIP_SELECT <= grant ? sel_onehot : '0;
			TRANSFER_ACKNOWLEDGE <= grant;
		end
	end

	// Bus monitor ends blocked or unmapped access
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			TRANSFER_ERROR <= 1'b0;
		end else begin
			TRANSFER_ERROR <= bus_mon_en && ACC_REQ && (blocked || !any_hit);
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ACC_PORT_WIDTH <= WIDTH_NONE;
			ACC_MACHINE <= MACH_NONE;
			ACC_PARITY_ENABLE <= 1'b0;
		end else if (grant) begin
			ACC_PORT_WIDTH <= width_of(sel_base[PORTW_LSB +: 2]);
			ACC_MACHINE <= machine_of(sel_base[MSEL_LSB +: 2]);
			ACC_PARITY_ENABLE <= sel_base[PAR_EN_BIT];
		end else begin
			ACC_PORT_WIDTH <= WIDTH_NONE;
			ACC_MACHINE <= MACH_NONE;
			ACC_PARITY_ENABLE <= 1'b0;
		end
	end

	assign pif.sel = prescale_select;
	assign ptimer_tick = pif.tick;

	ptimer_prescaler u_prescaler (
		.clk(CLK),
		.rst_n(RST_N),
		.baud_pin(BAUD_GEN_CLOCK),
		.pif(pif)
	);

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			PTIMER_TICK <= 1'b0;
		end else begin
			PTIMER_TICK <= ptimer_tick;
		end
	end

	// Checks
	logic boot_seen;
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			boot_seen <= 1'b0;
		end else begin
			boot_seen <= 1'b1;
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	property p_cs_valid;
		|BANK_CHIP_SELECT |-> ($past(valid_vec) & BANK_CHIP_SELECT) == BANK_CHIP_SELECT;
	endproperty
	a_cs_valid: assert property (p_cs_valid) else $error("chip select on invalid bank");

	property p_wp_block;
		blocked |=> BANK_CHIP_SELECT == '0 && !TRANSFER_ACKNOWLEDGE && err_flags[WP_FLAG];
	endproperty
	a_wp_block: assert property (p_wp_block) else $error("protected write not blocked");

	property p_wp_tea;
		blocked && bus_mon_en |=> TRANSFER_ERROR ##1 err_flags[WP_FLAG] || !$past(status_wr);
	endproperty
	a_wp_tea: assert property (p_wp_tea) else $error("protected write without error");

	property p_par_set;
		PAR_ERROR && par_armed |=> err_flags[$past(par_bank)];
	endproperty
	a_par_set: assert property (p_par_set) else $error("parity flag not set");

	property p_par_off;
		PAR_ERROR && !par_armed && !blocked |=> (err_flags & ~$past(err_flags)) == '0;
	endproperty
	a_par_off: assert property (p_par_off) else $error("parity flag set while disabled");

	property p_flag_keep;
		1'b1 |=> ($past(err_flags) & ~$past(clr_mask) & ~err_flags) == '0;
	endproperty
	a_flag_keep: assert property (p_flag_keep) else $error("flag lost without clear");

	property p_boot;
		!boot_seen |-> bank_base[0][V_BIT];
	endproperty
	a_boot: assert property (p_boot) else $error("boot bank not valid");

	property p_boot_mask;
		!boot_seen |-> bank_option[0][BA_LSB +: BA_W] == '0;
	endproperty
	a_boot_mask: assert property (p_boot_mask) else $error("boot mask not cleared");

	property p_width;
		grant |=> ACC_PORT_WIDTH == width_of($past(sel_base[PORTW_LSB +: 2])) && TRANSFER_ACKNOWLEDGE;
	endproperty
	a_width: assert property (p_width) else $error("port width wrong");

	property p_machine;
		grant && sel_base[MSEL_LSB +: 2] == MSEL_B |=> ACC_MACHINE == MACH_B;
	endproperty
	a_machine: assert property (p_machine) else $error("machine select wrong");

	property p_cs_cause;
		|BANK_CHIP_SELECT |-> $past(ACC_REQ) && $onehot(BANK_CHIP_SELECT);
	endproperty
	a_cs_cause: assert property (p_cs_cause) else $error("chip select without request");

	c_grant: cover property (grant ##1 TRANSFER_ACKNOWLEDGE);
	c_blocked: cover property (blocked ##1 TRANSFER_ERROR);
	c_parity: cover property (PAR_ERROR && par_armed ##1 status_wr);
	c_tick: cover property (PTIMER_TICK);
endmodule : memctl_regs
`default_nettype wire

// *** memory_bank_config_status_test.sv ***
`timescale 1ns/10ps
`default_nettype none
module memory_bank_config_status_test;
	import memctl_pkg::*;
	localparam logic [19:0] NONE = 20'h00000;
	localparam logic [19:0] XFER_ERR = 20'h00400;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic baud = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic acc_req = 1'b0;
	logic [31:0] acc_addr = 32'h0000_0000;
	logic [2:0] acc_type = 3'h0;
	logic acc_write = 1'b0;
	logic par_error;
	logic [7:0] bad_parity = 8'h00;
	logic [7:0] cs;
	logic ack, xfer_err, pe, tick;
	logic [5:0] width;
	logic [2:0] mach;
	int n_mismatch = 0;
	int n_checks = 0;
	logic [5:0] wtab [4] = '{WIDTH_32, WIDTH_8, WIDTH_16, WIDTH_NONE};
	logic [2:0] mtab [4] = '{MACH_GEN, MACH_NONE, MACH_A, MACH_B};
	logic [15:0] rsv [3] = '{16'h8000, 16'h4000, 16'h0000};

	always #4 clk = ~clk;
	always #33 baud = ~baud;

	memctl_regs u_memctl_regs (.CLK(clk), .RST_N(rst_n), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
		.ACC_REQ(acc_req), .ACC_ADDR(acc_addr), .ACC_TYPE(acc_type), .ACC_WRITE(acc_write),
		.PAR_ERROR(par_error), .BAUD_GEN_CLOCK(baud), .BANK_CHIP_SELECT(cs),
		.TRANSFER_ACKNOWLEDGE(ack), .TRANSFER_ERROR(xfer_err), .ACC_PORT_WIDTH(width),
		.ACC_MACHINE(mach), .ACC_PARITY_ENABLE(pe), .PTIMER_TICK(tick));

	mem_bank_model u_mem_bank_model (.clk(clk), .rst_n(rst_n), .acc_req(acc_req),
		.acc_write(acc_write), .cs(cs), .bad_parity(bad_parity), .par_error(par_error));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp, what);
	endtask : rchk

	function automatic logic [19:0] hit(input logic [7:0] c, input logic [5:0] w,
		input logic [2:0] m, input logic p);
		return {c, 1'b1, 1'b0, w, m, p};
	endfunction : hit

	task automatic acc(input logic [31:0] ad, input logic [2:0] ty, input logic w,
		input logic [19:0] exp, input string what);
		@(posedge clk);
		acc_req <= 1'b1;
		acc_addr <= ad;
		acc_type <= ty;
		acc_write <= w;
		@(posedge clk);
		acc_req <= 1'b0;
		#1 chk({12'h000, cs, ack, xfer_err, width, mach, pe}, {12'h000, exp}, what);
	endtask : acc

	task automatic t_regs;
		rchk(8'h40, BASE0_RST, "bank0 base reset");
		rchk(8'h44, OPT0_RST, "bank0 option reset");
		rchk(8'h48, REG_RST, "bank1 base reset");
		rchk(OFS_STATUS, REG_RST, "status reset");
		wr(8'h3C, 32'hFFFF_FFFF);
		rchk(8'h3C, 32'h0000_0000, "unmapped");
		wr(8'h78, BASE_WMASK);
		rchk(8'h78, BASE_WMASK, "bank7 base");
		wr(8'h7C, 32'hA5A5_5A5A);
		rchk(8'h7C, 32'hA5A5_5A5A, "bank7 option");
		wr(8'h78, 32'h0000_0000);
		$display("%0t done: registers", $time);
	endtask : t_regs

	task automatic t_match;
		acc(32'h1234_5678, 3'h5, 1'b0, hit(8'h01, WIDTH_32, MACH_GEN, 1'b0), "boot");
		wr(8'h40, 32'h0000_0000);
		acc(32'h1234_5678, 3'h5, 1'b0, NONE, "bank0 invalid");
		wr(8'h48, 32'h1000_3001);
		wr(8'h4C, 32'hFFFF_F000);
		acc(32'h1000_7FFF, 3'h3, 1'b0, hit(8'h02, WIDTH_32, MACH_GEN, 1'b0), "hit");
		acc(32'h1000_0000, 3'h2, 1'b0, NONE, "type miss");
		acc(32'h1001_0000, 3'h3, 1'b0, NONE, "addr miss");
		wr(8'h4C, 32'hFFFE_8000);
		acc(32'h1001_0000, 3'h6, 1'b0, hit(8'h02, WIDTH_32, MACH_GEN, 1'b0), "masked");
		wr(8'h48, 32'h1000_3000);
		acc(32'h1000_0000, 3'h3, 1'b0, NONE, "bank1 invalid");
		wr(8'h4C, 32'hFFFF_F000);
		$display("%0t done: matching", $time);
	endtask : t_match

	task automatic t_attrs;
		for (int i = 0; i < 4; i++) begin
			wr(8'h48, 32'h1000_3001 | (32'(i) << 10) | (32'(i) << 6) | (32'(i % 2) << 9));
			acc(32'h1000_0000, 3'h3, 1'b0, hit(8'h02, wtab[i], mtab[i], i[0]), "attrs");
		end
		$display("%0t done: attributes", $time);
	endtask : t_attrs

	task automatic t_wprot;
		wr(8'h48, 32'h1000_3101);
		acc(32'h1000_0000, 3'h3, 1'b1, NONE, "wp write");
		rchk(OFS_STATUS, 32'h0000_0080, "wp flag");
		wr(OFS_STATUS, 32'h0000_0000);
		rchk(OFS_STATUS, 32'h0000_0080, "wp flag kept");
		wr(OFS_STATUS, 32'h0000_0080);
		rchk(OFS_STATUS, 32'h0000_0000, "wp flag clear");
		acc(32'h1000_0000, 3'h3, 1'b0, hit(8'h02, WIDTH_32, MACH_GEN, 1'b0), "wp read");
		wr(OFS_CONTROL, 32'h0000_0001);
		acc(32'h1000_0000, 3'h3, 1'b1, XFER_ERR, "wp write monitor");
		rchk(OFS_STATUS, 32'h0000_0080, "monitor cause");
		acc(32'h2000_0000, 3'h3, 1'b0, XFER_ERR, "no hit monitor");
		wr(OFS_CONTROL, 32'h0000_0000);
		wr(OFS_STATUS, 32'h0000_0080);
		$display("%0t done: write protect", $time);
	endtask : t_wprot

	task automatic t_parity;
		bad_parity <= 8'h06;
		wr(8'h48, 32'h1000_3201);
		wr(8'h50, 32'h2000_3001);
		wr(8'h54, 32'hFFFF_F000);
		acc(32'h1000_0000, 3'h3, 1'b0, hit(8'h02, WIDTH_32, MACH_GEN, 1'b1), "par read");
		repeat (2) @(posedge clk);
		rchk(OFS_STATUS, 32'h0000_4000, "par flag");
		acc(32'h2000_0000, 3'h3, 1'b0, hit(8'h04, WIDTH_32, MACH_GEN, 1'b0), "no par");
		repeat (2) @(posedge clk);
		rchk(OFS_STATUS, 32'h0000_4000, "par disabled");
		wr(OFS_STATUS, 32'h0000_4000);
		acc(32'h1000_0000, 3'h3, 1'b1, hit(8'h02, WIDTH_32, MACH_GEN, 1'b1), "par write");
		repeat (2) @(posedge clk);
		rchk(OFS_STATUS, 32'h0000_0000, "par clear");
		$display("%0t done: parity", $time);
	endtask : t_parity

	task automatic count_ticks(input logic [15:0] sel, input int cyc, output int cnt);
		wr(OFS_PRESCALE, {16'h0000, sel});
		repeat (cyc) @(posedge clk);
		cnt = 0;
		repeat (cyc) begin
			@(posedge clk);
			#1 if (tick === 1'b1) cnt++;
		end
	endtask : count_ticks

	task automatic t_prescale;
		int cnt;
		for (int k = 0; k < 6; k++) begin
			count_ticks(16'h2000 >> k, 66 * (2 << k), cnt);
			chk(32'((cnt >= 7) && (cnt <= 9)), 32'h1, "prescale ticks");
		end
		for (int j = 0; j < 3; j++) begin
			count_ticks(rsv[j], 1000, cnt);
			chk(32'(cnt), 32'h0, "reserved prescale");
		end
		$display("%0t done: prescaler", $time);
	endtask : t_prescale

	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test

	initial begin
		repeat (60000) @(posedge clk);
		n_mismatch++;
		$display("[FAIL] %0t watchdog expired", $time);
		finish_test();
	end

	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_match();
		t_attrs();
		t_wprot();
		t_parity();
		t_prescale();
		finish_test();
	end
endmodule : memory_bank_config_status_test
`default_nettype wire

// *** prescale_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface prescale_if;
	logic [7:0] sel;
	logic tick;
	modport ctrl(output sel, input tick);
	modport div(input sel, output tick);
endinterface : prescale_if
`default_nettype wire

// *** ptimer_prescaler.sv ***
`timescale 1ns/10ps
`default_nettype none
module ptimer_prescaler
	import memctl_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic baud_pin,
	prescale_if.div pif
);
	logic [2:0] sync;
	logic level;
	logic [DIV_W-1:0] count;
	logic [DIV_W-1:0] divisor;

	// One-hot select to divide ratio, highest set bit decides
	function automatic logic [DIV_W-1:0] divide_of(input logic [PSEL_W-1:0] s);
		logic [DIV_W-1:0] d;
		d = DIV_NONE;
		if (s[7] || s[6]) begin
			d = DIV_NONE;
		end else if (s[5]) begin
			d = 7'h02;
		end else if (s[4]) begin
			d = 7'h04;
		end else if (s[3]) begin
			d = 7'h08;
		end else if (s[2]) begin
			d = 7'h10;
		end else if (s[1]) begin
			d = 7'h20;
		end else if (s[0]) begin
			d = 7'h40;
		end
		return d;
	endfunction : divide_of

	assign divisor = divide_of(pif.sel);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync <= 3'h0;
		end else begin
			sync <= {sync[1:0], baud_pin};
		end
	end

	// Level accepted once the later two stages agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			level <= 1'b0;
		end else if (sync[1] == sync[2]) begin
			level <= sync[2];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= DIV_NONE;
			pif.tick <= 1'b0;
		end else begin
			pif.tick <= 1'b0;
			if (divisor == DIV_NONE) begin
				count <= DIV_NONE;
			end else if (sync[1] == sync[2] && sync[2] && !level) begin
				if (count + 7'h01 >= divisor) begin
					count <= DIV_NONE;
					pif.tick <= 1'b1;
				end else begin
					count <= count + 7'h01;
				end
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_no_tick_reserved;
		pif.tick |-> $past(divisor) != DIV_NONE;
	endproperty
	a_no_tick_reserved: assert property (p_no_tick_reserved) else $error("tick on reserved select");
	c_tick: cover property (pif.tick);
endmodule : ptimer_prescaler
`default_nettype wire
